// *** src/sram_bwm_pkg.sv ***
package sram_bwm_pkg;
  // one lane of write data and its select
  localparam int LANE_W = 9;
  // lane counts of the two widths
  localparam int LANES_NARROW = 2;
  localparam int LANES_WIDE = 4;
  // burst address bits, array holds one double word per address
  localparam int ADDR_W = 8;
  // input synchroniser depth and strap settle count
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // array contents after reset are undefined, register values are not
  localparam logic RESET_OE_N = 1'b1;

  typedef enum logic [1:0]
  {
    W_IDLE = 2'b00,
    W_SECOND = 2'b01,
    W_COMMIT = 2'b10
  } wr_state_t;

  typedef enum logic [2:0]
  {
    R_IDLE = 3'b000,
    R_WAIT = 3'b001,
    R_FIRST = 3'b010,
    R_SECOND = 3'b011,
    R_DONE = 3'b100
  } rd_state_t;
endpackage : sram_bwm_pkg

// *** src/lane_merge.sv ***
`timescale 1ns/1ns
module lane_merge #(
  parameter int LANES = 2,
  parameter int LANE_W = 9
) (
  input wire logic [LANES*LANE_W-1:0] old_word,
  input wire logic [LANES*LANE_W-1:0] new_word,
  input wire logic [LANES-1:0] sel_n,
  output logic [LANES*LANE_W-1:0] merged
);
  // each lane takes new data only while its select is low
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    assign merged[i*LANE_W +: LANE_W] = sel_n[i] ? old_word[i*LANE_W +: LANE_W]
                                                 : new_word[i*LANE_W +: LANE_W];
  end
endmodule : lane_merge

// *** src/sram_byte_write_mask.sv ***
// Behaviour
// - narrow width: both selects low write all eighteen bits of the word
// - narrow width: select 0 low only writes bits 8:0, 17:9 kept
// - narrow width: select 1 low only writes bits 17:9, 8:0 kept
// - narrow width: both selects high write nothing of that word
// - wide width: each of four selects gates its own nine-bit lane
// - wide width: all four selects low write the whole 36-bit word
// - wide width: all four selects high leave memory untouched
// - word 0 taken on positive input clock rise, word 1 on negative
// - select pattern may change between words; each applies to its own word
// - first word goes to address A+0, second to A+1
// - after power-up deselected with read outputs released
// - read data timed by output clocks, input clocks in single clock mode
// - both captured words committed together, masked, at the latched address
`timescale 1ns/1ns
module sram_byte_write_mask #(
  parameter int LANES = sram_bwm_pkg::LANES_NARROW,
  parameter int ADDR_W = sram_bwm_pkg::ADDR_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic c_clk,
  input wire logic c_clk_n,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [ADDR_W-1:0] write_addr,
  input wire logic [ADDR_W-1:0] read_addr,
  input wire logic [LANES*sram_bwm_pkg::LANE_W-1:0] data_in,
  input wire logic [LANES-1:0] byte_lane_select_n,
  output logic [LANES*sram_bwm_pkg::LANE_W-1:0] q_data,
  output logic q_oe_n,
  output logic single_clock_mode
);
  localparam int DW = LANES * sram_bwm_pkg::LANE_W;
  localparam int NIN = 6 + 2 * ADDR_W + DW + LANES; // four clocks and two port selects

  // only the narrow and wide lane maps exist; the array index stays sane
  if ((LANES != sram_bwm_pkg::LANES_NARROW && LANES != sram_bwm_pkg::LANES_WIDE)
      || ADDR_W < 1 || ADDR_W > 20)
  begin : g_bad_params
    $error("LANES must be 2 or 4 and ADDR_W 1 to 20");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: every pin passes two flops before any logic
  logic [NIN-1:0] pins;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  logic [3:0] edge_prev_reg;

  assign pins = {k_clk, k_clk_n, c_clk, c_clk_n, write_port_select_n, read_port_select_n,
                 write_addr, read_addr, data_in, byte_lane_select_n};

  // data and clocks share one delay so captures stay aligned to their edge
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      edge_prev_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      edge_prev_reg <= sync2_reg[NIN-1 -: 4]; // previous k, k_n, c, c_n
    end
  end

  wire k_s = sync2_reg[NIN-1];
  wire kn_s = sync2_reg[NIN-2];
  wire c_s = sync2_reg[NIN-3];
  wire cn_s = sync2_reg[NIN-4];
  wire wsel_n_s = sync2_reg[NIN-5];
  wire rsel_n_s = sync2_reg[NIN-6];
  wire [ADDR_W-1:0] waddr_s = sync2_reg[NIN-7 -: ADDR_W];
  wire [ADDR_W-1:0] raddr_s = sync2_reg[NIN-7-ADDR_W -: ADDR_W];
  wire [DW-1:0] data_s = sync2_reg[LANES +: DW];
  wire [LANES-1:0] sel_s = sync2_reg[LANES-1:0];

  // edges from the synchronised copies only, never from the raw pins
  wire k_rise = k_s & ~edge_prev_reg[3];
  wire kn_rise = kn_s & ~edge_prev_reg[2];
  wire c_rise = c_s & ~edge_prev_reg[1];
  wire cn_rise = cn_s & ~edge_prev_reg[0];

  //////////////////////////////////////////////////////////////////////////////
  // single clock strap: both output clocks high once the synchroniser settled
  logic [1:0] strap_cnt_reg;
  logic single_reg;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      strap_cnt_reg <= 2'h0;
      single_reg <= 1'b0;
    end
    else if (strap_cnt_reg != sram_bwm_pkg::STRAP_SETTLE)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == sram_bwm_pkg::STRAP_SETTLE - 2'h1)
        single_reg <= c_s & cn_s;
    end
  end

  assign single_clock_mode = single_reg;
  // output references fall back to the input clocks in single clock mode
  wire out_pos_rise = single_reg ? k_rise : c_rise;
  wire out_neg_rise = single_reg ? kn_rise : cn_rise;

  //////////////////////////////////////////////////////////////////////////////
  // write port
  sram_bwm_pkg::wr_state_t wr_state_reg;
  sram_bwm_pkg::wr_state_t wr_state_next;
  logic [DW-1:0] word0_reg;
  logic [DW-1:0] word1_reg;
  logic [LANES-1:0] sel0_reg;
  logic [LANES-1:0] sel1_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [2*DW-1:0] mem [0:(1<<ADDR_W)-1];
  logic [2*DW-1:0] old_word;
  logic [2*DW-1:0] merged;

  wire start_write = k_rise & ~wsel_n_s;
  wire take_second = (wr_state_reg == sram_bwm_pkg::W_SECOND) & kn_rise;
  wire do_commit = (wr_state_reg == sram_bwm_pkg::W_COMMIT);

  // next state; a new write may start in the commit cycle
  always_comb
  begin
    case (wr_state_reg)
      sram_bwm_pkg::W_IDLE:
        wr_state_next = start_write ? sram_bwm_pkg::W_SECOND : sram_bwm_pkg::W_IDLE;
      sram_bwm_pkg::W_SECOND:
        wr_state_next = kn_rise ? sram_bwm_pkg::W_COMMIT : sram_bwm_pkg::W_SECOND;
      sram_bwm_pkg::W_COMMIT:
        wr_state_next = start_write ? sram_bwm_pkg::W_SECOND : sram_bwm_pkg::W_IDLE;
      default:
        wr_state_next = sram_bwm_pkg::W_IDLE;
    endcase
  end

  // word 0 and its selects on positive rise, address and word 1 on negative rise
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      wr_state_reg <= sram_bwm_pkg::W_IDLE;
      word0_reg <= '0;
      word1_reg <= '0;
      sel0_reg <= '1;
      sel1_reg <= '1;
      wr_addr_reg <= '0;
    end
    else
    begin
      wr_state_reg <= wr_state_next;
      if (start_write && wr_state_reg != sram_bwm_pkg::W_SECOND)
      begin
        word0_reg <= data_s;
        sel0_reg <= sel_s;
      end
      if (take_second)
      begin
        word1_reg <= data_s;
        sel1_reg <= sel_s;
        wr_addr_reg <= waddr_s;
      end
    end
  end

  // word 0 is the low half (A+0), word 1 the high half (A+1)
  assign old_word = mem[wr_addr_reg];
  lane_merge #(
    .LANES(2 * LANES),
    .LANE_W(sram_bwm_pkg::LANE_W)
  ) u_merge (
    .old_word(old_word),
    .new_word({word1_reg, word0_reg}),
    .sel_n({sel1_reg, sel0_reg}),
    .merged(merged)
  );

  // one array write per burst keeps masked lanes intact
  always_ff @(posedge clock)
  begin
    if (do_commit)
      mem[wr_addr_reg] <= merged;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port, kept only as far as output timing and power-up release
  sram_bwm_pkg::rd_state_t rd_state_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [DW-1:0] q_reg;
  logic oe_n_reg;
  wire [2*DW-1:0] rd_word = mem[rd_addr_reg];

  // no write forwarding: a read racing a pending commit sees old data
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rd_state_reg <= sram_bwm_pkg::R_IDLE;
      rd_addr_reg <= '0;
      q_reg <= '0;
      oe_n_reg <= sram_bwm_pkg::RESET_OE_N;
    end
    else
    begin
      case (rd_state_reg)
        sram_bwm_pkg::R_IDLE:
          if (k_rise && !rsel_n_s)
          begin
            rd_addr_reg <= raddr_s;
            rd_state_reg <= sram_bwm_pkg::R_WAIT;
          end
        sram_bwm_pkg::R_WAIT:
          if (k_rise)
            rd_state_reg <= sram_bwm_pkg::R_FIRST;
        sram_bwm_pkg::R_FIRST:
          if (out_neg_rise)
          begin
            q_reg <= rd_word[DW-1:0];
            oe_n_reg <= 1'b0;
            rd_state_reg <= sram_bwm_pkg::R_SECOND;
          end
        sram_bwm_pkg::R_SECOND:
          if (out_pos_rise)
          begin
            q_reg <= rd_word[2*DW-1:DW];
            rd_state_reg <= sram_bwm_pkg::R_DONE;
          end
        sram_bwm_pkg::R_DONE:
          if (out_neg_rise)
          begin
            oe_n_reg <= 1'b1;
            rd_state_reg <= sram_bwm_pkg::R_IDLE;
          end
        default:
          rd_state_reg <= sram_bwm_pkg::R_IDLE;
      endcase
    end
  end

  assign q_data = q_reg;
  assign q_oe_n = oe_n_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  AST_START: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_state_reg == sram_bwm_pkg::W_IDLE && k_rise && !wsel_n_s)
    |=> (wr_state_reg == sram_bwm_pkg::W_SECOND && word0_reg == $past(data_s)))
    else $error("write start not taken on positive rise");

  AST_ADDR: assert property (@(posedge clock) disable iff (!reset_n)
    take_second |=> (do_commit && wr_addr_reg == $past(waddr_s)))
    else $error("burst address not latched on negative rise");

  AST_SEL_PER_WORD: assert property (@(posedge clock) disable iff (!reset_n)
    take_second |=> (sel1_reg == $past(sel_s) && sel0_reg == $past(sel0_reg)))
    else $error("select pattern applied to the wrong word");

  AST_FULL: assert property (@(posedge clock) disable iff (!reset_n)
    (do_commit && sel0_reg == '0 && sel1_reg == '0) |-> merged == {word1_reg, word0_reg})
    else $error("full word not written");

  AST_NONE: assert property (@(posedge clock) disable iff (!reset_n)
    (do_commit && &sel0_reg && &sel1_reg) |=> mem[$past(wr_addr_reg)] == $past(old_word))
    else $error("masked burst altered memory");

  AST_LANE0: assert property (@(posedge clock) disable iff (!reset_n)
    (do_commit && sel0_reg == {{(LANES-1){1'b1}}, 1'b0})
    |-> (merged[8:0] == word0_reg[8:0] && merged[DW-1:9] == old_word[DW-1:9]))
    else $error("lane 0 write wrong");

  AST_LANE1: assert property (@(posedge clock) disable iff (!reset_n)
    (do_commit && sel1_reg[1] == 1'b0 && sel1_reg[0] == 1'b1)
    |-> (merged[DW+17:DW+9] == word1_reg[17:9] && merged[DW+8:DW] == old_word[DW+8:DW]))
    else $error("lane 1 write wrong");

  AST_COMMIT: assert property (@(posedge clock) disable iff (!reset_n)
    do_commit |=> mem[$past(wr_addr_reg)] == $past(merged))
    else $error("burst not committed");

  AST_POWERUP_HIZ: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> (q_oe_n && rd_state_reg == sram_bwm_pkg::R_IDLE))
    else $error("outputs driven after reset");

  AST_READ_EDGE: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(q_oe_n) |-> $past(out_neg_rise))
    else $error("read data not timed by output clock");
endmodule : sram_byte_write_mask

// *** dv/sram_ctrl_model.sv ***
`timescale 1ns/1ns
// memory controller model: drives both ports as pin levels, one task per burst
module sram_ctrl_model #(
  parameter int LANES = 4,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic [LANES*sram_bwm_pkg::LANE_W-1:0] q_data,
  input wire logic q_oe_n,
  output logic k_clk,
  output logic k_clk_n,
  output logic c_clk,
  output logic c_clk_n,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [ADDR_W-1:0] write_addr,
  output logic [ADDR_W-1:0] read_addr,
  output logic [LANES*sram_bwm_pkg::LANE_W-1:0] data_in,
  output logic [LANES-1:0] byte_lane_select_n
);
  ////////////////////////////////////////////////////////////////////////////////
  logic one_clk;

  // idle: input clocks equal; output clocks low so the strap reads dual clock
  initial
  begin
    one_clk = 1'b0;
    k_clk = 1'b0;
    k_clk_n = 1'b0;
    c_clk = 1'b0;
    c_clk_n = 1'b0;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    write_addr = '0;
    read_addr = '0;
    data_in = '0;
    byte_lane_select_n = '1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // both output clocks parked high pick single clock mode at the next reset
  task automatic strap(input logic on);
    one_clk = on;
    c_clk = on;
    c_clk_n = on;
  endtask : strap

  // mask is {k, k_n, c, c_n}; each level held four clocks, the synchroniser needs three
  task automatic pulse(input logic [3:0] m);
    {k_clk, k_clk_n, c_clk, c_clk_n} = {k_clk, k_clk_n, c_clk, c_clk_n} | m;
    repeat (4) @(negedge clock);
    {k_clk, k_clk_n, c_clk, c_clk_n} = {k_clk, k_clk_n, c_clk, c_clk_n} & ~m;
    repeat (4) @(negedge clock);
  endtask : pulse

  // write burst: select and word 0 at k rise, address and word 1 at k_n rise
  task automatic wr(input logic en_n, input logic [ADDR_W-1:0] a,
    input logic [LANES*9-1:0] d0, input logic [LANES-1:0] s0,
    input logic [LANES*9-1:0] d1, input logic [LANES-1:0] s1);
    @(negedge clock);
    write_port_select_n = en_n;
    data_in = d0;
    byte_lane_select_n = s0;
    pulse(4'h8);
    write_port_select_n = 1'b1;
    write_addr = a;
    data_in = d1;
    byte_lane_select_n = s1;
    pulse(4'h4);
    // released lines show the inverse, not a stale value
    data_in = ~d1;
    write_addr = ~a;
  endtask : wr

  // read burst: low half after c_n rise, high half after c rise, then release
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [LANES*9-1:0] lo,
    output logic [LANES*9-1:0] hi, output logic oe_on, output logic oe_off);
    logic [3:0] neg_ref;
    logic [3:0] pos_ref;
    // single clock mode times the outputs from k_n and k instead of c_n and c
    neg_ref = one_clk ? 4'h4 : 4'h1;
    pos_ref = one_clk ? 4'h8 : 4'h2;
    @(negedge clock);
    read_port_select_n = 1'b0;
    read_addr = a;
    pulse(4'h8);
    read_port_select_n = 1'b1;
    read_addr = ~a;
    pulse(4'h8);
    pulse(neg_ref);
    lo = q_data;
    oe_on = q_oe_n;
    pulse(pos_ref);
    hi = q_data;
    pulse(neg_ref);
    oe_off = q_oe_n;
  endtask : rd
endmodule : sram_ctrl_model

// *** dv/tb_sram_byte_write_mask.sv ***
`timescale 1ns/1ns
module tb_sram_byte_write_mask;
  localparam int LANES = sram_bwm_pkg::LANES_WIDE;
  localparam int ADDR_W = sram_bwm_pkg::ADDR_W;
  localparam int LW = sram_bwm_pkg::LANE_W;
  localparam int W = LANES*LW;
  logic clock;
  logic reset_n;
  logic k_clk;
  logic k_clk_n;
  logic c_clk;
  logic c_clk_n;
  logic write_port_select_n;
  logic read_port_select_n;
  logic [ADDR_W-1:0] write_addr;
  logic [ADDR_W-1:0] read_addr;
  logic [W-1:0] data_in;
  logic [LANES-1:0] byte_lane_select_n;
  logic [W-1:0] q_data;
  logic q_oe_n;
  logic single_clock_mode;
  int n_fail;
  int checked;
  logic [31:0] rnd;
  // reference array, one double word per address
  logic [2*W-1:0] mem [int];

  ////////////////////////////////////////////////////////////////////////////////
  sram_byte_write_mask #(.LANES(LANES), .ADDR_W(ADDR_W)) uut (.clock, .reset_n, .k_clk,
    .k_clk_n, .c_clk, .c_clk_n, .write_port_select_n, .read_port_select_n, .write_addr,
    .read_addr, .data_in, .byte_lane_select_n, .q_data, .q_oe_n, .single_clock_mode);
  sram_ctrl_model #(.LANES(LANES), .ADDR_W(ADDR_W)) ctl (.clock, .q_data, .q_oe_n, .k_clk,
    .k_clk_n, .c_clk, .c_clk_n, .write_port_select_n, .read_port_select_n, .write_addr,
    .read_addr, .data_in, .byte_lane_select_n);

  // 50 ns period
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [W-1:0] rw();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return W'({rnd, ~rnd});
  endfunction : rw

  task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, model %h", $time, got, exp);
    end
  endtask : check

  // burst plus model update; a refused burst leaves the model alone
  task automatic wr(input logic en_n, input int a, input logic [LANES-1:0] s0,
    input logic [LANES-1:0] s1);
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    d0 = rw();
    d1 = rw();
    ctl.wr(en_n, a[ADDR_W-1:0], d0, s0, d1, s1);
    for (int i = 0; i < LANES; i++)
    begin
      if (!en_n && !s0[i]) mem[a][LW*i +: LW] = d0[LW*i +: LW];
      if (!en_n && !s1[i]) mem[a][W+LW*i +: LW] = d1[LW*i +: LW];
    end
  endtask : wr

  task automatic rd(input int a);
    logic [W-1:0] lo;
    logic [W-1:0] hi;
    logic oe_on;
    logic oe_off;
    ctl.rd(a[ADDR_W-1:0], lo, hi, oe_on, oe_off);
    check(lo, mem[a][W-1:0]);
    check(hi, mem[a][2*W-1:W]);
    check(W'(oe_on), W'(0));
    check(W'(oe_off), W'(1));
  endtask : rd

  task automatic test_done();
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard, far beyond the roughly 1600 cycles the sequence needs
  initial
  begin
    repeat (90000) @(posedge clock);
    n_fail++;
    $display("unexpected at %0t: run too long", $time);
    test_done();
  end

  // main sequence
  initial
  begin
    n_fail = 0;
    checked = 0;
    rnd = 32'h25bc8406;
    reset_n = 1'b0;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    check(W'(q_oe_n), W'(1));
    check(W'(single_clock_mode), W'(0));
    $display("test reset done");
    // full writes, top address included, since array content starts undefined
    for (int a = 0; a < 5; a++)
    begin
      wr(1'b0, (a == 4) ? 255 : a, '0, '0);
      rd((a == 4) ? 255 : a);
    end
    $display("test full write done");
    // one lane per word, a different lane in each word
    for (int i = 0; i < LANES; i++)
    begin
      wr(1'b0, 1, ~(LANES'(1) << i), ~(LANES'(1) << (LANES - 1 - i)));
      rd(1);
    end
    $display("test lane write done");
    wr(1'b0, 2, '1, '1);
    rd(2);
    // select high at k rise must not write
    wr(1'b1, 3, '0, '0);
    rd(3);
    $display("test masked and refused done");
    // random lanes and data over the filled addresses
    for (int n = 0; n < 12; n++)
    begin
      wr(1'b0, rnd[1:0], rnd[5:2], rnd[9:6]);
      rd(rnd[11:10]);
    end
    $display("test random done");
    // mid-run reset with both output clocks strapped high: single clock mode
    ctl.strap(1'b1);
    @(negedge clock);
    reset_n = 1'b0;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    check(W'(q_oe_n), W'(1));
    check(W'(single_clock_mode), W'(1));
    // array keeps its words across reset, so the model still holds
    for (int n = 0; n < 4; n++)
    begin
      wr(1'b0, n, rnd[3:0], rnd[7:4]);
      rd(n);
    end
    $display("test single clock done");
    test_done();
  end
endmodule : tb_sram_byte_write_mask
